// File: design/i2ccs_top.sv
// serial transfer clock select for three two-wire channels
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/10ps
`include "i2ccs_params.svh"
module i2ccs_top #(
  parameter int NUM_CH = 3
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic [3:0]       addr_i,
  input  wire logic [7:0]       wdata_i,
  input  wire logic [7:0]       wbit_mask_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [7:0]       rdata_o,
  output logic      [NUM_CH-1:0] bus_unit_enable_o,
  output logic      [NUM_CH-1:0] clk_valid_o,
  output logic      [NUM_CH-1:0] serial_clock_o
);
  logic        rst_s1_reg;
  logic        rst_s2_reg;
  wire         rst_n;

  i2ccs_pkg::i2ccs_byte_t fexp_reg [NUM_CH];
  i2ccs_pkg::i2ccs_byte_t csel_reg [NUM_CH];
  i2ccs_pkg::i2ccs_byte_t ctrl_reg [NUM_CH];
  i2ccs_pkg::i2ccs_byte_t div_reg  [2];
  i2ccs_pkg::i2ccs_byte_t rdata_reg;
  i2ccs_pkg::i2ccs_byte_t rdata_next;

  i2ccs_pkg::i2ccs_presc_t presc   [NUM_CH];
  i2ccs_pkg::i2ccs_ratio_t ratio   [NUM_CH];
  logic                    legal   [NUM_CH];
  logic                    use_div [NUM_CH];

  // reset is asserted at once and released through two flops
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // division code to prescale; 0 means stopped or unlisted code
  function automatic i2ccs_pkg::i2ccs_presc_t div_presc(input i2ccs_pkg::i2ccs_byte_t code);
    unique case (code)
      `I2CCS_DIV_THROUGH: div_presc = 3'd1;
      `I2CCS_DIV_BY2:     div_presc = 3'd2;
      `I2CCS_DIV_BY3:     div_presc = 3'd3;
      `I2CCS_DIV_BY4:     div_presc = 3'd4;
      `I2CCS_DIV_BY5:     div_presc = 3'd5;
      default:            div_presc = 3'd0;
    endcase
  endfunction

  // merge a byte write with a bit mask so single-bit writes leave neighbours alone
  function automatic i2ccs_pkg::i2ccs_byte_t merge(input i2ccs_pkg::i2ccs_byte_t old,
                                                   input i2ccs_pkg::i2ccs_byte_t val,
                                                   input i2ccs_pkg::i2ccs_byte_t msk);
    merge = (old & ~msk) | (val & msk);
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      wire       ext  = fexp_reg[g][`I2CCS_EXT_SPEED_BIT];
      wire       smc  = csel_reg[g][`I2CCS_SPEED_MODE_BIT];
      wire       rhi  = csel_reg[g][`I2CCS_RATIO_HI_BIT];
      wire       rlo  = csel_reg[g][`I2CCS_RATIO_LO_BIT];
      wire [2:0] dp   = div_presc(div_reg[(g == 0) ? 0 : 1]);
      logic [8:0] r;
      logic       ok;
      logic       ud;
      always_comb begin
        r  = 9'd0;
        ok = 1'b0;
        ud = 1'b1;
        // extended speed is looked at in both modes; set in standard mode it leaves no ratio, so the clock is not valid
        if (!smc) begin
          if (!ext) begin
            unique case ({rhi, rlo})
              2'b00: begin r = `I2CCS_RATIO_STD0; ok = 1'b1; end
              2'b01: begin r = `I2CCS_RATIO_STD1; ok = (dp <= 3'd4); end
              2'b10: begin r = `I2CCS_RATIO_STD1; ok = 1'b1; ud = 1'b0; end
              2'b11: begin r = `I2CCS_RATIO_STD3; ok = (dp <= 3'd3); end
            endcase
          end
        end else if (!ext) begin
          if (!rhi) begin
            r = `I2CCS_RATIO_HS0;
            ok = (dp <= 3'd4);
          end else if (!rlo) begin
            r = `I2CCS_RATIO_HS0;
            ok = 1'b1;
            ud = 1'b0;
          end else begin
            r = `I2CCS_RATIO_HS3;
            ok = (dp <= 3'd3);
          end
        end else begin
          if (!rhi) begin
            r = `I2CCS_RATIO_EXT;
            ok = 1'b1;
          end else if (!rlo) begin
            r = `I2CCS_RATIO_EXT;
            ok = 1'b1;
            ud = 1'b0;
          end
        end
      end
      assign use_div[g] = ud;
      // ratio 10 runs on the main clock whatever the division register holds
      assign presc[g] = ud ? dp : 3'd1;
      assign ratio[g] = r;
      // an unlisted or stopped prescale leaves the clock idle instead of guessing
      assign legal[g] = ok && (presc[g] != 3'd0);
      assign bus_unit_enable_o[g] = ctrl_reg[g][`I2CCS_ENABLE_BIT];
      assign clk_valid_o[g] = legal[g];

      i2ccs_chan_gen u_gen (
        .clock_i (clock_i),
        .rst_n_i (rst_n),
        .run_i   (bus_unit_enable_o[g] && legal[g]),
        .presc_i (presc[g]),
        .ratio_i (ratio[g]),
        .scl_o   (serial_clock_o[g])
      );
    end
  endgenerate

  wire [1:0] ch_f = addr_i[1:0];
  wire       hit_fexp = (addr_i[3:2] == 2'b00) && (ch_f < 2'(NUM_CH));
  wire       hit_csel = (addr_i[3:2] == 2'b01) && (ch_f < 2'(NUM_CH));
  wire       hit_ctrl = (addr_i[3:2] == 2'b11) && (ch_f < 2'(NUM_CH));
  wire       hit_div  = (addr_i == `I2CCS_ADDR_DIV0) || (addr_i == `I2CCS_ADDR_DIV1);

  // registers; a write while the channel is enabled still lands, software must avoid it
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        fexp_reg[i] <= `I2CCS_RESET_BYTE;
        csel_reg[i] <= `I2CCS_RESET_BYTE;
        ctrl_reg[i] <= `I2CCS_RESET_BYTE;
      end
      div_reg[0] <= `I2CCS_RESET_BYTE;
      div_reg[1] <= `I2CCS_RESET_BYTE;
    end else if (wr_i) begin
      if (hit_fexp)
        fexp_reg[ch_f] <= merge(fexp_reg[ch_f], wdata_i, wbit_mask_i);
      if (hit_csel)
        csel_reg[ch_f] <= merge(csel_reg[ch_f], wdata_i, wbit_mask_i & `I2CCS_CSEL_WMASK);
      if (hit_ctrl)
        ctrl_reg[ch_f] <= merge(ctrl_reg[ch_f], wdata_i, wbit_mask_i);
      if (hit_div)
        div_reg[addr_i[0]] <= wdata_i;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (hit_fexp)
      rdata_next = fexp_reg[ch_f];
    else if (hit_csel)
      rdata_next = csel_reg[ch_f];
    else if (hit_ctrl)
      rdata_next = ctrl_reg[ch_f];
    else if (hit_div)
      rdata_next = div_reg[addr_i[0]];
    else if (addr_i == `I2CCS_ADDR_STATUS)
      rdata_next = {5'h00, clk_valid_o};
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rd_i ? rdata_next : 8'h00;
  end
  assign rdata_o = rdata_reg;

  // checks
  property p_fexp_reset;
    @(posedge clock_i) $rose(rst_n) |-> fexp_reg[0] == 8'h00 && fexp_reg[2] == 8'h00;
  endproperty
  a_fexp_reset: assert property (p_fexp_reset) else $error("expansion not cleared at reset");

  property p_bit_write;
    @(posedge clock_i) disable iff (!rst_n)
      wr_i && addr_i == `I2CCS_ADDR_FEXP0 && wbit_mask_i == 8'h01
      |=> fexp_reg[0][7:1] == $past(fexp_reg[0][7:1]) && fexp_reg[0][0] == $past(wdata_i[0]);
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("single-bit write disturbed others");

  property p_ext_std;
    @(posedge clock_i) disable iff (!rst_n)
      !csel_reg[0][3] && csel_reg[0][1:0] == 2'b00 && fexp_reg[0][0] |-> ratio[0] == 9'd0;
  endproperty
  a_ext_std: assert property (p_ext_std) else $error("extended speed acted in standard mode");

  property p_range;
    @(posedge clock_i) disable iff (!rst_n)
      legal[1] |-> ratio[1] * presc[1] >= 12 && ratio[1] * presc[1] <= 344;
  endproperty
  a_range: assert property (p_range) else $error("overall ratio outside 12..344");

  property p_std0;
    @(posedge clock_i) disable iff (!rst_n)
      csel_reg[0][3:0] == 4'h0 && !fexp_reg[0][0] |-> ratio[0] == 9'd44;
  endproperty
  a_std0: assert property (p_std0) else $error("standard ratio 00 not 44");

  property p_std1;
    @(posedge clock_i) disable iff (!rst_n)
      csel_reg[0][3:0] == 4'h1 && !fexp_reg[0][0] && div_reg[0] == 8'h13 |-> !legal[0];
  endproperty
  a_std1: assert property (p_std1) else $error("divide by five allowed with ratio 01");

  property p_undiv;
    @(posedge clock_i) disable iff (!rst_n)
      csel_reg[2][1:0] == 2'b10 && !fexp_reg[2][0] |-> presc[2] == 3'd1 && !use_div[2];
  endproperty
  a_undiv: assert property (p_undiv) else $error("ratio 10 used the divider");

  property p_share;
    @(posedge clock_i) disable iff (!rst_n)
      csel_reg[1][3:0] == 4'h0 && csel_reg[2][3:0] == 4'h0 |-> presc[1] == presc[2];
  endproperty
  a_share: assert property (p_share) else $error("channels one and two differ in prescale");

  sequence s_stopped;
    !bus_unit_enable_o[0] ##1 !bus_unit_enable_o[0];
  endsequence
  property p_idle_high;
    @(posedge clock_i) disable iff (!rst_n) s_stopped |=> serial_clock_o[0];
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("serial clock low while stopped");

  property p_read_zero;
    @(posedge clock_i) disable iff (!rst_n) !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("read data outside read slot");
endmodule

// File: design/i2ccs_params.svh
// constants for the serial transfer clock select block
`ifndef I2CCS_PARAMS_SVH
`define I2CCS_PARAMS_SVH
// register addresses (4-bit index space)
`define I2CCS_ADDR_FEXP0     4'h0
`define I2CCS_ADDR_FEXP1     4'h1
`define I2CCS_ADDR_FEXP2     4'h2
`define I2CCS_ADDR_CSEL0     4'h4
`define I2CCS_ADDR_CSEL1     4'h5
`define I2CCS_ADDR_CSEL2     4'h6
`define I2CCS_ADDR_DIV0      4'h8
`define I2CCS_ADDR_DIV1      4'h9
`define I2CCS_ADDR_CTRL0     4'hc
`define I2CCS_ADDR_CTRL1     4'hd
`define I2CCS_ADDR_CTRL2     4'he
`define I2CCS_ADDR_STATUS    4'hf
// field positions
`define I2CCS_EXT_SPEED_BIT  0
`define I2CCS_SPEED_MODE_BIT 3
`define I2CCS_RATIO_HI_BIT   1
`define I2CCS_RATIO_LO_BIT   0
`define I2CCS_ENABLE_BIT     7
`define I2CCS_CSEL_WMASK     8'h0f
// reset value
`define I2CCS_RESET_BYTE     8'h00
// division clock register codes
`define I2CCS_DIV_THROUGH    8'h18
`define I2CCS_DIV_BY2        8'h10
`define I2CCS_DIV_BY3        8'h11
`define I2CCS_DIV_BY4        8'h12
`define I2CCS_DIV_BY5        8'h13
// serial clock ratios against the selection clock
`define I2CCS_RATIO_STD0     9'd44
`define I2CCS_RATIO_STD1     9'd86
`define I2CCS_RATIO_STD3     9'd66
`define I2CCS_RATIO_HS0      9'd24
`define I2CCS_RATIO_HS3      9'd18
`define I2CCS_RATIO_EXT      9'd12
`define I2CCS_RATIO_MIN      9'd12
`define I2CCS_RATIO_MAX      9'd344
`endif

// File: design/i2ccs_pkg.sv
// types for the serial transfer clock select block
package i2ccs_pkg;
  typedef logic [7:0] i2ccs_byte_t;
  typedef logic [8:0] i2ccs_ratio_t;
  typedef logic [2:0] i2ccs_presc_t;
  typedef enum logic [1:0] {
    I2CCS_ST_IDLE = 2'b00,
    I2CCS_ST_LOW  = 2'b01,
    I2CCS_ST_HIGH = 2'b11
  } i2ccs_state_t;
endpackage

// File: design/i2ccs_chan_gen.sv
// one channel serial clock generator from prescale and ratio
`timescale 1ns/10ps
`include "i2ccs_params.svh"
module i2ccs_chan_gen (
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 run_i,
  input  wire i2ccs_pkg::i2ccs_presc_t presc_i,
  input  wire i2ccs_pkg::i2ccs_ratio_t ratio_i,
  output logic                      scl_o
);
  i2ccs_pkg::i2ccs_presc_t pre_reg;
  i2ccs_pkg::i2ccs_presc_t pre_next;
  i2ccs_pkg::i2ccs_ratio_t cnt_reg;
  i2ccs_pkg::i2ccs_ratio_t cnt_next;
  i2ccs_pkg::i2ccs_state_t st_reg;
  i2ccs_pkg::i2ccs_state_t st_next;
  logic                     scl_reg;
  wire                      tick;
  wire i2ccs_pkg::i2ccs_ratio_t half;
  wire                      half_end;

  // one tick per selection clock cycle; the serial period is ratio ticks
  assign tick     = (pre_reg == presc_i - 3'd1);
  assign half     = {1'b0, ratio_i[8:1]};
  assign half_end = tick && (cnt_reg == half - 9'd1);
  assign pre_next = (!run_i || tick) ? 3'd0 : pre_reg + 3'd1;

  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    if (!run_i) begin
      st_next  = i2ccs_pkg::I2CCS_ST_IDLE;
      cnt_next = 9'd0;
    end else begin
      unique case (st_reg)
        i2ccs_pkg::I2CCS_ST_IDLE: begin
          st_next  = i2ccs_pkg::I2CCS_ST_LOW;
          cnt_next = 9'd0;
        end
        i2ccs_pkg::I2CCS_ST_LOW: begin
          cnt_next = tick ? cnt_reg + 9'd1 : cnt_reg;
          if (half_end) begin
            st_next  = i2ccs_pkg::I2CCS_ST_HIGH;
            cnt_next = 9'd0;
          end
        end
        i2ccs_pkg::I2CCS_ST_HIGH: begin
          cnt_next = tick ? cnt_reg + 9'd1 : cnt_reg;
          if (half_end) begin
            st_next  = i2ccs_pkg::I2CCS_ST_LOW;
            cnt_next = 9'd0;
          end
        end
        default: begin
          st_next  = i2ccs_pkg::I2CCS_ST_IDLE;
          cnt_next = 9'd0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_reg <= 3'd0;
      cnt_reg <= 9'd0;
      st_reg  <= i2ccs_pkg::I2CCS_ST_IDLE;
      scl_reg <= 1'b1;
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      st_reg  <= st_next;
      scl_reg <= (st_next != i2ccs_pkg::I2CCS_ST_LOW);
    end
  end

  assign scl_o = scl_reg;
endmodule

// File: tb/i2ccs_line_mon.sv
// far-side observer that times the serial clock in main clock cycles
`timescale 1ns/10ps
module i2ccs_line_mon (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        scl_i,
  output logic      [15:0] period_o
);
  logic        scl_q;
  logic [15:0] cnt;
  // the line has a pull-up, so a pin that is not driven low reads high
  wire         scl_line = (scl_i === 1'b0) ? 1'b0 : 1'b1;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q    <= 1'b1;
      cnt      <= 16'h0000;
      period_o <= 16'h0000;
    end else begin
      scl_q <= scl_line;
      if (scl_line && !scl_q) begin
        period_o <= cnt + 16'h0001;
        cnt      <= 16'h0000;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule

// File: tb/i2ccs_top_tb.sv
// self-checking bench for the serial transfer clock select block
`timescale 1ns/10ps
`include "i2ccs_params.svh"
module i2ccs_top_tb;
  logic        clock_i;
  logic        rst_n_i;
  logic [3:0]  addr_i;
  logic [7:0]  wdata_i;
  logic [7:0]  wbit_mask_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  rdata_o;
  logic [2:0]  bus_unit_enable_o;
  logic [2:0]  clk_valid_o;
  logic [2:0]  serial_clock_o;
  logic [15:0] period[3];
  int          mismatches;
  int          num_checks;

  i2ccs_top #(.NUM_CH(3)) i_dut (
    .clock_i           (clock_i),
    .rst_n_i           (rst_n_i),
    .addr_i            (addr_i),
    .wdata_i           (wdata_i),
    .wbit_mask_i       (wbit_mask_i),
    .wr_i              (wr_i),
    .rd_i              (rd_i),
    .rdata_o           (rdata_o),
    .bus_unit_enable_o (bus_unit_enable_o),
    .clk_valid_o       (clk_valid_o),
    .serial_clock_o    (serial_clock_o)
  );

  for (genvar g = 0; g < 3; g++) begin : g_mon
    i2ccs_line_mon i_mon (
      .clock_i  (clock_i),
      .rst_n_i  (rst_n_i),
      .scl_i    (serial_clock_o[g]),
      .period_o (period[g])
    );
  end

  always #20 clock_i = ~clock_i;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clock_i);
    addr_i      <= a;
    wdata_i     <= d;
    wbit_mask_i <= m;
    wr_i        <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk({8'h00, rdata_o}, {8'h00, exp}, what);
  endtask

  // channel zero is stopped before any setup write, as software must do
  task automatic run_case(input logic [7:0] fx, input logic [7:0] cs, input logic [7:0] dv,
                          input logic [15:0] exp);
    wr(`I2CCS_ADDR_CTRL0, 8'h00, 8'hff);
    wr(`I2CCS_ADDR_FEXP0, fx, 8'hff);
    wr(`I2CCS_ADDR_CSEL0, cs, 8'hff);
    wr(`I2CCS_ADDR_DIV0, dv, 8'hff);
    wr(`I2CCS_ADDR_CTRL0, 8'h80, 8'hff);
    repeat (4 * int'(exp) + 20) @(posedge clock_i);
    #1;
    chk({15'h0000, clk_valid_o[0]}, {15'h0000, exp != 16'h0000}, "clock valid");
    if (exp != 16'h0000)
      chk(period[0], exp, "serial period");
    else
      chk({15'h0000, serial_clock_o[0]}, 16'h0001, "stopped clock idles high");
    $display("test case fexp %h csel %h div %h done", fx, cs, dv);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock_i);
    mismatches++;
    $display("FAIL at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    clock_i     = 1'b0;
    rst_n_i     = 1'b0;
    addr_i      = 4'h0;
    wdata_i     = 8'h00;
    wbit_mask_i = 8'h00;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);

    rd_chk(`I2CCS_ADDR_FEXP0, 8'h00, "fexp0 reset");
    rd_chk(`I2CCS_ADDR_FEXP1, 8'h00, "fexp1 reset");
    rd_chk(`I2CCS_ADDR_FEXP2, 8'h00, "fexp2 reset");
    $display("test reset values done");

    wr(`I2CCS_ADDR_FEXP1, 8'hff, 8'h01);
    rd_chk(`I2CCS_ADDR_FEXP1, 8'h01, "single bit set");
    wr(`I2CCS_ADDR_FEXP1, 8'ha5, 8'hff);
    rd_chk(`I2CCS_ADDR_FEXP1, 8'ha5, "byte write");
    wr(`I2CCS_ADDR_FEXP1, 8'h00, 8'h04);
    rd_chk(`I2CCS_ADDR_FEXP1, 8'ha1, "single bit clear");
    wr(`I2CCS_ADDR_FEXP1, 8'h00, 8'hff);
    wr(`I2CCS_ADDR_FEXP0, 8'h7e, 8'hff);
    wr(`I2CCS_ADDR_FEXP0, 8'hff, 8'h01);
    rd_chk(`I2CCS_ADDR_FEXP0, 8'h7f, "bit zero set beside others");
    wr(`I2CCS_ADDR_FEXP0, 8'h00, 8'hff);
    wr(4'h3, 8'h5a, 8'hff);
    rd_chk(4'h3, 8'h00, "unmapped address");
    $display("test register access done");

    run_case(8'h00, 8'h00, `I2CCS_DIV_THROUGH, 16'd44);
    run_case(8'h00, 8'h00, `I2CCS_DIV_BY5, 16'd220);
    run_case(8'h00, 8'h01, `I2CCS_DIV_BY4, 16'd344);
    run_case(8'h00, 8'h02, 8'h00, 16'd86);
    run_case(8'h00, 8'h03, `I2CCS_DIV_BY3, 16'd198);
    run_case(8'h00, 8'h09, `I2CCS_DIV_BY2, 16'd48);
    run_case(8'h00, 8'h0e, 8'h00, 16'd24);
    run_case(8'h00, 8'h0b, `I2CCS_DIV_BY3, 16'd54);
    run_case(8'h01, 8'h08, `I2CCS_DIV_BY5, 16'd60);
    run_case(8'h01, 8'h0a, 8'h00, 16'd12);
    run_case(8'h01, 8'h00, `I2CCS_DIV_THROUGH, 16'd0);
    run_case(8'h01, 8'h0b, `I2CCS_DIV_THROUGH, 16'd0);

    // channels one and two share the second division register
    wr(`I2CCS_ADDR_CTRL0, 8'h00, 8'hff);
    wr(`I2CCS_ADDR_FEXP0, 8'h00, 8'hff);
    wr(`I2CCS_ADDR_CSEL0, 8'h00, 8'hff);
    wr(`I2CCS_ADDR_DIV0, `I2CCS_DIV_THROUGH, 8'hff);
    wr(`I2CCS_ADDR_DIV1, `I2CCS_DIV_BY4, 8'hff);
    wr(`I2CCS_ADDR_CTRL0, 8'h80, 8'hff);
    wr(`I2CCS_ADDR_CTRL1, 8'h80, 8'hff);
    wr(`I2CCS_ADDR_CTRL2, 8'h80, 8'hff);
    repeat (4 * 176 + 20) @(posedge clock_i);
    #1;
    chk(period[0], 16'd44, "channel zero period");
    chk(period[1], 16'd176, "channel one period");
    chk(period[2], 16'd176, "channel two period");
    chk({13'h0000, bus_unit_enable_o}, 16'h0007, "all channels enabled");
    rd_chk(`I2CCS_ADDR_STATUS, 8'h07, "all channels valid");
    $display("test shared division register done");

    // ratio 10 on channel two ignores the shared division register; upper bits are not writable
    wr(`I2CCS_ADDR_CTRL2, 8'h00, 8'hff);
    wr(`I2CCS_ADDR_CSEL2, 8'hf2, 8'hff);
    rd_chk(`I2CCS_ADDR_CSEL2, 8'h02, "clock select upper bits");
    chk({13'h0000, bus_unit_enable_o}, 16'h0003, "channel two stopped");
    rd_chk(`I2CCS_ADDR_STATUS, 8'h07, "ratio 10 valid on channel two");
    $display("test undivided ratio on channel two done");
    close_out();
  end
endmodule
